/* hdl/cdc_pkg.sv */
package cdc_pkg;
    // bus geometry: one aligned 32-bit word per register, byte address = 4 * index
    localparam int ADDR_W = 9;
    localparam int IDX_W = 7;
    localparam int DATA_W = 32;
    localparam int IDX_LSB = 2;
    localparam int BYTE_W = 8;

    // configuration bank and its mirror in the non-volatile ram image
    localparam int CFG_COUNT = 48;
    localparam int MIRROR_AW = 6;

    // coined register indices of the configuration bank
    localparam logic [IDX_W-1:0] OSCILLATOR_TUNING_IDX = 7'h00;
    localparam logic [IDX_W-1:0] OSCILLATOR_CONTROL_IDX = 7'h01;
    localparam logic [IDX_W-1:0] DISCHARGE_RESISTOR_SELECT_IDX = 7'h02;
    localparam logic [IDX_W-1:0] AUXILIARY_CHARGE_OPTIONS_IDX = 7'h03;
    localparam logic [IDX_W-1:0] SENSOR_TOPOLOGY_IDX = 7'h04;
    localparam logic [IDX_W-1:0] MEASURE_CYCLE_OPTIONS_IDX = 7'h05;
    localparam logic [IDX_W-1:0] CHANNEL_ENABLE_MASK_IDX = 7'h06;
    localparam logic [IDX_W-1:0] AVERAGE_COUNT_LOW_IDX = 7'h07;
    localparam logic [IDX_W-1:0] AVERAGE_COUNT_HIGH_IDX = 7'h08;
    localparam logic [IDX_W-1:0] CONVERSION_PERIOD_BYTE0_IDX = 7'h09;
    localparam logic [IDX_W-1:0] CONVERSION_PERIOD_BYTE1_IDX = 7'h0A;
    localparam logic [IDX_W-1:0] CONVERSION_PERIOD_BYTE2_IDX = 7'h0B;
    localparam logic [IDX_W-1:0] DISCHARGE_DURATION_LOW_IDX = 7'h0C;
    localparam logic [IDX_W-1:0] FRONT_END_RUN_IDX = 7'h2F;

    // field positions
    localparam int FRONT_END_RUN_BIT = 0;
    localparam int TOPO_FLOATING_BIT = 0;
    localparam int TOPO_DIFFERENTIAL_BIT = 1;
    localparam int CHANNEL_COUNT = 6;

    // special function registers and extra views
    localparam logic [IDX_W-1:0] SFR_LOCK_IDX = 7'h30;
    localparam logic [IDX_W-1:0] SFR_SERIAL_IDX = 7'h31;
    localparam logic [IDX_W-1:0] SFR_STATUS_IDX = 7'h32;
    localparam logic [IDX_W-1:0] SFR_SCRATCH_IDX = 7'h33;
    localparam logic [IDX_W-1:0] IO_VIEW_LO_IDX = 7'h34;
    localparam logic [IDX_W-1:0] IO_VIEW_HI_IDX = 7'h35;
    localparam logic [IDX_W-1:0] RESULT_BASE_IDX = 7'h40;
    localparam int STATUS_RUN_BIT = 16;

    // dsp io: 64 readable bits of which 16 are driven back
    localparam int IO_VIEW_W = 64;
    localparam int IO_DRIVE_W = 16;
    localparam int STATUS_IN_W = IO_VIEW_W - IO_DRIVE_W;
    localparam int RESULT_COUNT = 8;
    localparam int RESULT_IDX_W = 3;

    // clocks, figures only; the dsp oscillator itself is analog
    localparam longint BUS_CLK_HZ = 40000000;
    localparam longint DSP_CLK_HZ = 60000000;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] RESET_WORD = 32'h00000000;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_WAIT = 2'b01,
        RD_RESP = 2'b10
    } rd_state_type;

    typedef enum logic [0:0] {
        DSP_RUNNING = 1'b0,
        DSP_HALTED = 1'b1
    } dsp_state_type;
endpackage

/* hdl/mirror_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface mirror_if #(parameter int AW = 6, parameter int DW = 8);
    logic we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

/* hdl/mirror_ram.sv */
`timescale 1ns/10ps
`default_nettype none
module mirror_ram #(
    parameter int DEPTH = 48
) (
    // clock
    input wire logic aclk,
    // access port
    mirror_if.mem port
);
    logic [7:0] store_r [DEPTH];
    logic [7:0] rdata_r;

    // write and registered read; no reset, contents are loaded by the host
    always_ff @(posedge aclk) begin
        if (port.we) begin
            store_r[port.waddr] <= port.wdata;
        end
        rdata_r <= store_r[port.raddr];
    end

    assign port.rdata = rdata_r;
endmodule
`default_nettype wire

/* hdl/cdc_config_and_dsp_wake.sv */
`timescale 1ns/10ps
`default_nettype none
module cdc_config_and_dsp_wake #(
    parameter logic [7:0] SERIAL_NUMBER = 8'hA5 // arbitrary value
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [cdc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [cdc_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [cdc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [cdc_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // dsp core side
    input wire logic dsp_halt_cmd,
    input wire logic gpio_wake,
    input wire logic meas_done,
    output logic dsp_clk_en,
    input wire logic [cdc_pkg::STATUS_IN_W-1:0] status_in,
    input wire logic dsp_io_wr_en,
    input wire logic [cdc_pkg::IO_DRIVE_W-1:0] dsp_io_wr_data,
    output logic [cdc_pkg::IO_VIEW_W-1:0] dsp_io_view,
    output logic [cdc_pkg::IO_DRIVE_W-1:0] gpio_out,
    input wire logic result_wr_en,
    input wire logic [cdc_pkg::RESULT_IDX_W-1:0] result_wr_idx,
    input wire logic [cdc_pkg::DATA_W-1:0] result_wr_data,
    // front end configuration
    output logic [cdc_pkg::CFG_COUNT*8-1:0] cfg_bytes,
    output logic front_end_run,
    output logic [cdc_pkg::CHANNEL_COUNT-1:0] channel_enable_mask,
    output logic sensor_floating,
    output logic sensor_differential
);
    localparam int IW = cdc_pkg::IDX_W;

    // index lies in the configuration bank
    function automatic logic is_cfg(input logic [IW-1:0] idx);
        return idx < IW'(cdc_pkg::CFG_COUNT);
    endfunction

    // index lies in the result window
    function automatic logic is_result(input logic [IW-1:0] idx);
        return idx >= cdc_pkg::RESULT_BASE_IDX
            && idx < IW'(cdc_pkg::RESULT_BASE_IDX + cdc_pkg::RESULT_COUNT);
    endfunction

    mirror_if #(.AW(cdc_pkg::MIRROR_AW), .DW(8)) mir ();

    mirror_ram #(.DEPTH(cdc_pkg::CFG_COUNT)) u_mirror (
        .aclk(aclk),
        .port(mir)
    );

    // write channel state
    logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
    logic awready_r, awready_nxt, wready_r, wready_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic [IW-1:0] widx_r, widx_nxt;
    logic [cdc_pkg::DATA_W-1:0] wdata_r, wdata_nxt;
    logic wlane0_r, wlane0_nxt;
    logic do_write;

    // config bank and special function registers
    logic [cdc_pkg::CFG_COUNT-1:0][7:0] cfg_r, cfg_nxt;
    logic [7:0] lock_r, lock_nxt, scratch_r, scratch_nxt;

    // address and data may arrive in either order; one write at a time
    always_comb begin
        aw_have_nxt = aw_have_r;
        w_have_nxt = w_have_r;
        widx_nxt = widx_r;
        wdata_nxt = wdata_r;
        wlane0_nxt = wlane0_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        do_write = aw_have_r && w_have_r && !bvalid_r;
        if (s_axi_awvalid && awready_r) begin
            aw_have_nxt = 1'b1;
            widx_nxt = s_axi_awaddr[cdc_pkg::ADDR_W-1:cdc_pkg::IDX_LSB];
        end
        if (s_axi_wvalid && wready_r) begin
            w_have_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wlane0_nxt = s_axi_wstrb[0];
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (do_write) begin
            aw_have_nxt = 1'b0;
            w_have_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = (is_cfg(widx_r) || widx_r == cdc_pkg::SFR_LOCK_IDX
                || widx_r == cdc_pkg::SFR_SCRATCH_IDX) ? cdc_pkg::RESP_OKAY
                : cdc_pkg::RESP_SLVERR;
        end
        awready_nxt = !aw_have_nxt && !bvalid_nxt;
        wready_nxt = !w_have_nxt && !bvalid_nxt;
    end

    // register updates; only byte lane 0 carries data, upper lanes are ignored
    always_comb begin
        cfg_nxt = cfg_r;
        lock_nxt = lock_r;
        scratch_nxt = scratch_r;
        if (do_write && wlane0_r) begin
            if (is_cfg(widx_r)) begin
                cfg_nxt[widx_r[cdc_pkg::MIRROR_AW-1:0]] = wdata_r[7:0];
                if (widx_r == cdc_pkg::FRONT_END_RUN_IDX) begin
                    // single-bit register: other bits are kept at zero
                    cfg_nxt[widx_r[cdc_pkg::MIRROR_AW-1:0]] =
                        {7'h00, wdata_r[cdc_pkg::FRONT_END_RUN_BIT]};
                end
            end else if (widx_r == cdc_pkg::SFR_LOCK_IDX) begin
                lock_nxt = wdata_r[7:0];
            end else if (widx_r == cdc_pkg::SFR_SCRATCH_IDX) begin
                scratch_nxt = wdata_r[7:0];
            end
        end
    end

    // the mirror takes the very same write in the same cycle
    assign mir.we = do_write && wlane0_r && is_cfg(widx_r);
    assign mir.waddr = widx_r[cdc_pkg::MIRROR_AW-1:0];
    assign mir.wdata = cfg_nxt[widx_r[cdc_pkg::MIRROR_AW-1:0]];

    // write side registers; config holds its value until rewritten
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= cdc_pkg::RESP_OKAY;
            widx_r <= '0;
            wdata_r <= cdc_pkg::RESET_WORD;
            wlane0_r <= 1'b0;
            cfg_r <= '0;
            lock_r <= cdc_pkg::RESET_BYTE;
            scratch_r <= cdc_pkg::RESET_BYTE;
        end else begin
            aw_have_r <= aw_have_nxt;
            w_have_r <= w_have_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            widx_r <= widx_nxt;
            wdata_r <= wdata_nxt;
            wlane0_r <= wlane0_nxt;
            cfg_r <= cfg_nxt;
            lock_r <= lock_nxt;
            scratch_r <= scratch_nxt;
        end
    end

    // dsp clock gate, io and result registers
    cdc_pkg::dsp_state_type dsp_state_r, dsp_state_nxt;
    logic [cdc_pkg::IO_DRIVE_W-1:0] gpio_r, gpio_nxt;
    logic [cdc_pkg::IO_VIEW_W-1:0] view_r, view_nxt;
    logic [cdc_pkg::DATA_W-1:0] result_r [cdc_pkg::RESULT_COUNT];
    logic clk_en_r, clk_en_nxt;

    // a wake in the same cycle as a halt wins, so no event is lost
    always_comb begin
        dsp_state_nxt = dsp_state_r;
        case (dsp_state_r)
            cdc_pkg::DSP_RUNNING: begin
                if (dsp_halt_cmd && !(gpio_wake || meas_done)) begin
                    dsp_state_nxt = cdc_pkg::DSP_HALTED;
                end
            end
            cdc_pkg::DSP_HALTED: begin
                if (gpio_wake || meas_done) begin
                    dsp_state_nxt = cdc_pkg::DSP_RUNNING;
                end
            end
            default: dsp_state_nxt = cdc_pkg::DSP_RUNNING;
        endcase
        gpio_nxt = dsp_io_wr_en ? dsp_io_wr_data : gpio_r;
        view_nxt = {status_in, gpio_r};
        clk_en_nxt = dsp_state_nxt == cdc_pkg::DSP_RUNNING;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dsp_state_r <= cdc_pkg::DSP_RUNNING;
            clk_en_r <= 1'b1;
            gpio_r <= '0;
            view_r <= '0;
        end else begin
            dsp_state_r <= dsp_state_nxt;
            gpio_r <= gpio_nxt;
            view_r <= view_nxt;
            clk_en_r <= clk_en_nxt;
        end
    end

    // one result register per slot, written by the dsp firmware
    for (genvar g = 0; g < cdc_pkg::RESULT_COUNT; g++) begin : g_result
        logic [cdc_pkg::DATA_W-1:0] slot_nxt;
        always_comb begin
            slot_nxt = result_r[g];
            if (result_wr_en && result_wr_idx == cdc_pkg::RESULT_IDX_W'(g)) begin
                slot_nxt = result_wr_data;
            end
        end
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                result_r[g] <= cdc_pkg::RESET_WORD;
            end else begin
                result_r[g] <= slot_nxt;
            end
        end
    end

    // read channel: config bytes come back from the mirror, one extra cycle
    cdc_pkg::rd_state_type rd_state_r, rd_state_nxt;
    logic [IW-1:0] ridx_r, ridx_nxt;
    logic [cdc_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic arready_r, arready_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [cdc_pkg::RESULT_IDX_W-1:0] rslot;

    assign rslot = cdc_pkg::RESULT_IDX_W'(ridx_r - cdc_pkg::RESULT_BASE_IDX);
    assign mir.raddr = ridx_nxt[cdc_pkg::MIRROR_AW-1:0];

    always_comb begin
        rd_state_nxt = rd_state_r;
        ridx_nxt = ridx_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        case (rd_state_r)
            cdc_pkg::RD_IDLE: begin
                if (s_axi_arvalid && arready_r) begin
                    ridx_nxt = s_axi_araddr[cdc_pkg::ADDR_W-1:cdc_pkg::IDX_LSB];
                    rd_state_nxt = cdc_pkg::RD_WAIT;
                end
            end
            cdc_pkg::RD_WAIT: begin
                rresp_nxt = cdc_pkg::RESP_OKAY;
                rdata_nxt = cdc_pkg::RESET_WORD;
                if (is_cfg(ridx_r)) begin
                    rdata_nxt[7:0] = mir.rdata;
                end else if (is_result(ridx_r)) begin
                    rdata_nxt = result_r[rslot];
                end else begin
                    case (ridx_r)
                        cdc_pkg::SFR_LOCK_IDX: rdata_nxt[7:0] = lock_r;
                        cdc_pkg::SFR_SERIAL_IDX: rdata_nxt[7:0] = SERIAL_NUMBER;
                        cdc_pkg::SFR_STATUS_IDX: begin
                            rdata_nxt[cdc_pkg::IO_DRIVE_W-1:0] = gpio_r;
                            rdata_nxt[cdc_pkg::STATUS_RUN_BIT] =
                                dsp_state_r == cdc_pkg::DSP_RUNNING;
                        end
                        cdc_pkg::SFR_SCRATCH_IDX: rdata_nxt[7:0] = scratch_r;
                        cdc_pkg::IO_VIEW_LO_IDX: rdata_nxt = view_r[cdc_pkg::DATA_W-1:0];
                        cdc_pkg::IO_VIEW_HI_IDX:
                            rdata_nxt = view_r[cdc_pkg::IO_VIEW_W-1:cdc_pkg::DATA_W];
                        default: rresp_nxt = cdc_pkg::RESP_SLVERR;
                    endcase
                end
                rd_state_nxt = cdc_pkg::RD_RESP;
            end
            cdc_pkg::RD_RESP: begin
                if (s_axi_rready) begin
                    rd_state_nxt = cdc_pkg::RD_IDLE;
                end
            end
            default: rd_state_nxt = cdc_pkg::RD_IDLE;
        endcase
        arready_nxt = rd_state_nxt == cdc_pkg::RD_IDLE;
        rvalid_nxt = rd_state_nxt == cdc_pkg::RD_RESP;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_r <= cdc_pkg::RD_IDLE;
            ridx_r <= '0;
            rdata_r <= cdc_pkg::RESET_WORD;
            rresp_r <= cdc_pkg::RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
        end else begin
            rd_state_r <= rd_state_nxt;
            ridx_r <= ridx_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // outputs, all taken directly from flip-flops
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign dsp_clk_en = clk_en_r;
    assign gpio_out = gpio_r;
    assign dsp_io_view = view_r;
    assign cfg_bytes = cfg_r;
    assign front_end_run = cfg_r[cdc_pkg::FRONT_END_RUN_IDX][cdc_pkg::FRONT_END_RUN_BIT];
    assign channel_enable_mask =
        cfg_r[cdc_pkg::CHANNEL_ENABLE_MASK_IDX][cdc_pkg::CHANNEL_COUNT-1:0];
    assign sensor_floating = cfg_r[cdc_pkg::SENSOR_TOPOLOGY_IDX][cdc_pkg::TOPO_FLOATING_BIT];
    assign sensor_differential =
        cfg_r[cdc_pkg::SENSOR_TOPOLOGY_IDX][cdc_pkg::TOPO_DIFFERENTIAL_BIT];

    // checks on the bank, the mirror and the dsp gate
    logic cfg_wr;
    assign cfg_wr = do_write && wlane0_r && is_cfg(widx_r);

    chk_cfg_write_stored: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg_wr && widx_r != cdc_pkg::FRONT_END_RUN_IDX
        |=> cfg_r[$past(widx_r[cdc_pkg::MIRROR_AW-1:0])] == $past(wdata_r[7:0]))
        else $error("config write not stored");
    chk_mirror_same_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_state_r == cdc_pkg::RD_WAIT && is_cfg(ridx_r) && !$past(mir.we)
        |-> mir.rdata == cfg_r[ridx_r[cdc_pkg::MIRROR_AW-1:0]])
        else $error("mirror and register disagree");
    chk_run_bit_only: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg_wr && widx_r == cdc_pkg::FRONT_END_RUN_IDX
        |=> front_end_run == $past(wdata_r[0]) && cfg_r[cdc_pkg::FRONT_END_RUN_IDX][7:1] == 7'h00)
        else $error("run bit register wrong");
    chk_cfg_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        !cfg_wr |=> $stable(cfg_r))
        else $error("config changed without a write");
    chk_halt_stops: assert property (@(posedge aclk) disable iff (!aresetn)
        dsp_clk_en && dsp_halt_cmd && !gpio_wake && !meas_done |=> !dsp_clk_en)
        else $error("halt did not stop dsp clock");
    chk_wake_restarts: assert property (@(posedge aclk) disable iff (!aresetn)
        !dsp_clk_en && (gpio_wake || meas_done) |=> dsp_clk_en)
        else $error("dsp did not wake");
    chk_gpio_drive: assert property (@(posedge aclk) disable iff (!aresetn)
        dsp_io_wr_en |=> gpio_out == $past(dsp_io_wr_data) ##1
        dsp_io_view[cdc_pkg::IO_DRIVE_W-1:0] == $past(dsp_io_wr_data, 2))
        else $error("gpio drive or view wrong");
    chk_result_copy: assert property (@(posedge aclk) disable iff (!aresetn)
        result_wr_en |=> result_r[$past(result_wr_idx)] == $past(result_wr_data))
        else $error("result not stored");
    chk_read_latency: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid)
        else $error("read answer not two cycles later");
    chk_chan_mask: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg_wr && widx_r == cdc_pkg::CHANNEL_ENABLE_MASK_IDX
        |=> channel_enable_mask == $past(wdata_r[cdc_pkg::CHANNEL_COUNT-1:0]))
        else $error("channel mask wrong");

    cov_cfg_write: cover property (@(posedge aclk) disable iff (!aresetn) cfg_wr);
    cov_halt_wake: cover property (@(posedge aclk) disable iff (!aresetn)
        !dsp_clk_en ##1 dsp_clk_en);
    cov_read_back: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && s_axi_rready && is_cfg(ridx_r));
endmodule
`default_nettype wire

/* testbench/dsp_model.sv */
`timescale 1ns/10ps
`default_nettype none
module dsp_model #(
    parameter logic [47:0] STATUS = 48'h0
) (
    // clock
    input wire logic aclk,
    // firmware side towards the block
    output logic dsp_halt_cmd,
    output logic gpio_wake,
    output logic meas_done,
    output logic [47:0] status_in,
    output logic dsp_io_wr_en,
    output logic [15:0] dsp_io_wr_data,
    output logic result_wr_en,
    output logic [2:0] result_wr_idx,
    output logic [31:0] result_wr_data
);
    // quiet firmware at start; fixed status so the io view is predictable
    initial begin
        {dsp_halt_cmd, gpio_wake, meas_done, dsp_io_wr_en, result_wr_en} = 5'h00;
        {dsp_io_wr_data, result_wr_idx, result_wr_data} = '0;
        status_in = STATUS;
    end
    // one-cycle halt command and wake sources
    task automatic pulse(input logic h, input logic g, input logic m);
        @(posedge aclk);
        {dsp_halt_cmd, gpio_wake, meas_done} <= {h, g, m};
        @(posedge aclk);
        {dsp_halt_cmd, gpio_wake, meas_done} <= 3'h0;
    endtask
    // firmware drives the general-purpose pins
    task automatic io_write(input logic [15:0] v);
        @(posedge aclk);
        {dsp_io_wr_en, dsp_io_wr_data} <= {1'b1, v};
        @(posedge aclk);
        dsp_io_wr_en <= 1'b0;
    endtask
    // firmware copies a raw result into a host-readable slot
    task automatic res_write(input logic [2:0] k, input logic [31:0] v);
        @(posedge aclk);
        {result_wr_en, result_wr_idx, result_wr_data} <= {1'b1, k, v};
        @(posedge aclk);
        result_wr_en <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* testbench/cdc_config_and_dsp_wake_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module cdc_config_and_dsp_wake_tb;
    localparam logic [7:0] SER = 8'h5C; // arbitrary value
    localparam logic [47:0] STAT = 48'h0123456789AB;
    logic aclk = 0, aresetn = 0;
    logic [8:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0;
    logic [1:0] r;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic dsp_clk_en, front_end_run, sensor_floating, sensor_differential;
    wire logic dsp_halt_cmd, gpio_wake, meas_done, dsp_io_wr_en, result_wr_en;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata, result_wr_data;
    wire logic [63:0] dsp_io_view;
    wire logic [47:0] status_in;
    wire logic [15:0] gpio_out, dsp_io_wr_data;
    wire logic [2:0] result_wr_idx;
    wire logic [383:0] cfg_bytes;
    wire logic [5:0] channel_enable_mask;
    int n_errors = 0, n_tests = 0;

    cdc_config_and_dsp_wake #(.SERIAL_NUMBER(SER)) uut (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .dsp_halt_cmd, .gpio_wake, .meas_done, .dsp_clk_en, .status_in,
        .dsp_io_wr_en, .dsp_io_wr_data, .dsp_io_view, .gpio_out, .result_wr_en,
        .result_wr_idx, .result_wr_data, .cfg_bytes, .front_end_run, .channel_enable_mask,
        .sensor_floating, .sensor_differential);
    dsp_model #(.STATUS(STAT)) dsp (.aclk, .dsp_halt_cmd, .gpio_wake, .meas_done,
        .status_in, .dsp_io_wr_en, .dsp_io_wr_data, .result_wr_en, .result_wr_idx,
        .result_wr_data);

    always #12.5 aclk = ~aclk;

    // pattern per config byte; the last one keeps only its run bit
    function automatic logic [7:0] cfg_val(input int i);
        cfg_val = 8'(i * 37 + 17) & ((i == 47) ? 8'h01 : 8'hFF);
    endfunction

    // upper data bits carry junk on purpose: the block must drop them
    task automatic wr(input logic [8:0] a, input logic [7:0] v);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, 24'hFFFFFF, v};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [8:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #(25 * 20000);
        n_errors++;
        print_verdict;
    end

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 48; i++) begin
            wr(9'(4 * i), 8'(i * 37 + 17));
            `CHK(r, cdc_pkg::RESP_OKAY)
            `CHK(cfg_bytes[8*i+:8], cfg_val(i))
        end
        for (int i = 0; i < 48; i++) begin
            rd(9'(4 * i));
            `CHK(d, {24'h0, cfg_val(i)})
        end
        `CHK(front_end_run, 1'b0)
        wr(9'h0BC, 8'hFF);
        rd(9'h0BC);
        `CHK({front_end_run, d}, {1'b1, 32'h1})
        `CHK({channel_enable_mask, sensor_floating}, {6'h2F, 1'h1})
        wr(9'h010, 8'h02);
        `CHK({sensor_floating, sensor_differential}, 2'h1)
        // lane 0 strobe low: nothing may be stored
        s_axi_wstrb <= 4'h0;
        wr(9'h014, 8'h00);
        s_axi_wstrb <= 4'hF;
        `CHK(cfg_bytes[47:40], 8'hCA)
        rd(9'h014);
        `CHK(d, 32'hCA)
        // read-only serial byte, scratch, unmapped hole
        wr(9'h0C4, 8'h00);
        `CHK(r, cdc_pkg::RESP_SLVERR)
        rd(9'h0C4);
        `CHK({r, d}, {cdc_pkg::RESP_OKAY, 24'h0, SER})
        wr(9'h0CC, 8'h3C);
        rd(9'h0CC);
        `CHK(d, 32'h3C)
        wr(9'h0C0, 8'h5A);
        rd(9'h0C0);
        `CHK({r, d}, {cdc_pkg::RESP_OKAY, 32'h5A})
        wr(9'h0E0, 8'h11);
        `CHK(r, cdc_pkg::RESP_SLVERR)
        rd(9'h0E0);
        `CHK({r, d}, {cdc_pkg::RESP_SLVERR, 32'h0})
        // halt, then each wake source, then halt racing a wake
        dsp.pulse(1, 0, 0);
        #1 `CHK(dsp_clk_en, 1'b0)
        rd(9'h0C8);
        `CHK(d[16], 1'b0)
        dsp.pulse(0, 1, 0);
        #1 `CHK(dsp_clk_en, 1'b1)
        dsp.pulse(1, 0, 0);
        dsp.pulse(0, 0, 1);
        #1 `CHK(dsp_clk_en, 1'b1)
        dsp.pulse(1, 1, 0);
        #1 `CHK(dsp_clk_en, 1'b1)
        dsp.io_write(16'hC3A5);
        #1 `CHK(gpio_out, 16'hC3A5)
        @(posedge aclk);
        #1 `CHK(dsp_io_view, {STAT, 16'hC3A5})
        rd(9'h0C8);
        `CHK(d, {15'h0, 1'b1, 16'hC3A5})
        rd(9'h0D0);
        `CHK(d, {STAT[15:0], 16'hC3A5})
        rd(9'h0D4);
        `CHK(d, STAT[47:16])
        for (int k = 0; k < 8; k++) begin
            dsp.res_write(3'(k), 32'hA0B0C000 + k);
            rd(9'(9'h100 + 4 * k));
            `CHK(d, 32'hA0B0C000 + k)
        end
        print_verdict;
    end
endmodule
`default_nettype wire
